// >>> logic/rtcpit_regs.vh
// Overview of operation
// - Interval field bits 6:3; 0 off, 1..E give 4 doubling to 32768, F reserved.
// - Periodic timer runs only while control bit 0 enable is one.
// - Status bit 0 reads one while a control write is still crossing over.
// - Enable register bit 0 decides whether the periodic interrupt is passed on.
// - Flag sets each time the selected interval of clock cycles elapses.
// - Writing one to the flag clears it; writing zero leaves it alone.
// - While halted for debug, timer stops and ignores events unless run bit set.
`ifndef RTCPIT_REGS_VH
`define RTCPIT_REGS_VH

// Register indices; the byte address is four times the index.
`define RTCPIT_IDX_CTRL 6'h10
`define RTCPIT_IDX_STATUS 6'h11
`define RTCPIT_IDX_IRQ_EN 6'h12
`define RTCPIT_IDX_IRQ_FLAG 6'h13
`define RTCPIT_IDX_DEBUG 6'h15

// Field positions.
`define RTCPIT_CTRL_ENABLE_BIT 0
`define RTCPIT_CTRL_PERIOD_LSB 3
`define RTCPIT_CTRL_PERIOD_MSB 6
`define RTCPIT_STATUS_BUSY_BIT 0
`define RTCPIT_IRQ_BIT 0
`define RTCPIT_DEBUG_RUN_BIT 0

// Reset values.
`define RTCPIT_CTRL_RESET 8'h00
`define RTCPIT_IRQ_EN_RESET 8'h00
`define RTCPIT_IRQ_FLAG_RESET 8'h00
`define RTCPIT_DEBUG_RESET 8'h00

// Interval codes.
`define RTCPIT_PERIOD_OFF 4'h0
`define RTCPIT_PERIOD_RESERVED 4'hF
`define RTCPIT_PERIOD_BASE 16'h0004

// RTC clock edges a control write needs to take effect.
`define RTCPIT_SYNC_TICKS 2'h2

// Bus responses.
`define RTCPIT_RESP_OKAY 2'h0
`define RTCPIT_RESP_SLVERR 2'h2

`endif

// >>> logic/rtcpit_sync.v
`timescale 1ns/1ns
`default_nettype none

// Two flip-flop synchroniser for asynchronous levels.
module rtcpit_sync #(
    parameter WIDTH = 2
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Levels
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;

    always @(posedge aclk) begin
        if (!aresetn) begin
            stage1 <= {WIDTH{1'b0}};
            stage2 <= {WIDTH{1'b0}};
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
        end
    end

    assign sync_out = stage2;

endmodule

`default_nettype wire

// >>> logic/rtcpit_top.v
`timescale 1ns/1ns
`default_nettype none
`include "rtcpit_regs.vh"

module rtcpit_top #(
    parameter ADDR_W = 8
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Write address channel
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // Write data channel
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // Write response channel
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // Read address channel
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // Read data channel
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // RTC clock and debug halt, both asynchronous
    input wire rtc_clk_in,
    input wire cpu_debug_halted,
    // Interrupt and event outputs
    output reg tick_irq,
    output reg tick_event
);

    // Select codes of the register decoder.
    localparam SEL_NONE = 5'b00000;
    localparam SEL_CTRL = 5'b00001;
    localparam SEL_STATUS = 5'b00010;
    localparam SEL_IRQ_EN = 5'b00100;
    localparam SEL_IRQ_FLAG = 5'b01000;
    localparam SEL_DEBUG = 5'b10000;

    // States of the control crossing.
    localparam XFER_IDLE = 2'b01;
    localparam XFER_BUSY = 2'b10;

    // One-bit registers reset to bit 0 of their register's reset byte.
    localparam [7:0] IRQ_EN_RESET = `RTCPIT_IRQ_EN_RESET;
    localparam [7:0] IRQ_FLAG_RESET = `RTCPIT_IRQ_FLAG_RESET;
    localparam [7:0] DEBUG_RESET = `RTCPIT_DEBUG_RESET;

    function [4:0] reg_select;
        input [5:0] index;
        begin
            case (index)
                `RTCPIT_IDX_CTRL: reg_select = SEL_CTRL;
                `RTCPIT_IDX_STATUS: reg_select = SEL_STATUS;
                `RTCPIT_IDX_IRQ_EN: reg_select = SEL_IRQ_EN;
                `RTCPIT_IDX_IRQ_FLAG: reg_select = SEL_IRQ_FLAG;
                `RTCPIT_IDX_DEBUG: reg_select = SEL_DEBUG;
                default: reg_select = SEL_NONE;
            endcase
        end
    endfunction

    // Last count value of an interval; the interval is four doubled code-1 times.
    function [14:0] period_last;
        input [3:0] code;
        reg [15:0] cycles;
        begin
            cycles = `RTCPIT_PERIOD_BASE << (code - 4'h1);
            period_last = cycles[14:0] - 15'h0001;
        end
    endfunction

    // Software visible state.
    reg [7:0] ctrl_sys;
    reg irq_enable;
    reg irq_flag;
    reg run_when_halted;

    // Control copy that the timer uses.
    reg tick_timer_enable;
    reg [3:0] period_code;

    // Crossing state.
    reg [1:0] xfer_state;
    reg [1:0] xfer_ticks;
    wire control_sync_busy;

    // Write channel holding registers.
    reg aw_held;
    reg w_held;
    reg [5:0] aw_index;
    reg [7:0] w_byte;
    reg w_lane0;

    // Synchronised inputs and edge detection.
    wire [1:0] pins_sync;
    wire rtc_level;
    wire halted_level;
    reg rtc_level_prev;
    wire rtc_tick;

    // Timer.
    reg [14:0] tick_count;
    wire timer_active;
    wire interval_done;

    // Write strobes.
    wire write_fire;
    wire [4:0] write_sel;
    wire ctrl_write;
    wire flag_clear;

    rtcpit_sync #(
        .WIDTH(2)
    ) i_rtcpit_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in({cpu_debug_halted, rtc_clk_in}),
        .sync_out(pins_sync)
    );

    assign rtc_level = pins_sync[0];
    assign halted_level = pins_sync[1];

    always @(posedge aclk) begin
        if (!aresetn) begin
            rtc_level_prev <= 1'b0;
        end else begin
            rtc_level_prev <= rtc_level;
        end
    end

    // A rising RTC edge seen in the bus clock marks one RTC clock cycle.
    assign rtc_tick = rtc_level & ~rtc_level_prev;

    // Write channel.

    assign write_fire = aw_held & w_held & ~s_axi_bvalid;
    assign write_sel = reg_select(aw_index);
    assign ctrl_write = write_fire & w_lane0 & (write_sel == SEL_CTRL);
    assign flag_clear = write_fire & w_lane0 & (write_sel == SEL_IRQ_FLAG)
        & w_byte[`RTCPIT_IRQ_BIT];

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_index <= 6'h00;
            w_byte <= 8'h00;
            w_lane0 <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RTCPIT_RESP_OKAY;
        end else begin
            s_axi_awready <= ~aw_held & ~(s_axi_awvalid & s_axi_awready);
            s_axi_wready <= ~w_held & ~(s_axi_wvalid & s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_index <= s_axi_awaddr[7:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_byte <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
            end
            if (write_fire) begin
                s_axi_bvalid <= 1'b1;
                if (write_sel == SEL_NONE) begin
                    s_axi_bresp <= `RTCPIT_RESP_SLVERR;
                end else begin
                    s_axi_bresp <= `RTCPIT_RESP_OKAY;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Writable registers.
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_sys <= `RTCPIT_CTRL_RESET;
            irq_enable <= IRQ_EN_RESET[0];
            run_when_halted <= DEBUG_RESET[0];
        end else if (write_fire && w_lane0) begin
            if (write_sel == SEL_CTRL) begin
                ctrl_sys <= w_byte & 8'h79;
            end
            if (write_sel == SEL_IRQ_EN) begin
                irq_enable <= w_byte[`RTCPIT_IRQ_BIT];
            end
            if (write_sel == SEL_DEBUG) begin
                run_when_halted <= w_byte[`RTCPIT_DEBUG_RUN_BIT];
            end
        end
    end

    // Control crossing.

    // A control write takes effect after two RTC clock cycles; a new write restarts it.
    always @(posedge aclk) begin
        if (!aresetn) begin
            xfer_state <= XFER_IDLE;
            xfer_ticks <= 2'h0;
            tick_timer_enable <= 1'b0;
            period_code <= `RTCPIT_PERIOD_OFF;
        end else begin
            case (xfer_state)
                XFER_IDLE: begin
                    if (ctrl_write) begin
                        xfer_state <= XFER_BUSY;
                        xfer_ticks <= 2'h0;
                    end
                end
                XFER_BUSY: begin
                    if (ctrl_write) begin
                        xfer_ticks <= 2'h0;
                    end else if (rtc_tick) begin
                        if (xfer_ticks == `RTCPIT_SYNC_TICKS - 2'h1) begin
                            xfer_state <= XFER_IDLE;
                            tick_timer_enable <= ctrl_sys[`RTCPIT_CTRL_ENABLE_BIT];
                            period_code <=
                                ctrl_sys[`RTCPIT_CTRL_PERIOD_MSB:`RTCPIT_CTRL_PERIOD_LSB];
                        end else begin
                            xfer_ticks <= xfer_ticks + 2'h1;
                        end
                    end
                end
                default: begin
                    xfer_state <= XFER_IDLE;
                end
            endcase
        end
    end

    assign control_sync_busy = (xfer_state == XFER_BUSY);

    // Periodic timer.

    assign timer_active = tick_timer_enable
        & (period_code != `RTCPIT_PERIOD_OFF)
        & (period_code != `RTCPIT_PERIOD_RESERVED)
        & ~(halted_level & ~run_when_halted);

    assign interval_done = timer_active & rtc_tick
        & (tick_count == period_last(period_code));

    always @(posedge aclk) begin
        if (!aresetn) begin
            tick_count <= 15'h0000;
        end else if (!tick_timer_enable) begin
            tick_count <= 15'h0000;
        end else if (timer_active && rtc_tick) begin
            if (interval_done) begin
                tick_count <= 15'h0000;
            end else begin
                tick_count <= tick_count + 15'h0001;
            end
        end
    end

    // A tick in the same cycle as the clear keeps the flag set.
    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_flag <= IRQ_FLAG_RESET[0];
        end else if (interval_done) begin
            irq_flag <= 1'b1;
        end else if (flag_clear) begin
            irq_flag <= 1'b0;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            tick_irq <= 1'b0;
            tick_event <= 1'b0;
        end else begin
            tick_irq <= irq_flag & irq_enable;
            tick_event <= interval_done;
        end
    end

    // Read channel.

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RTCPIT_RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `RTCPIT_RESP_OKAY;
                case (reg_select(s_axi_araddr[7:2]))
                    SEL_CTRL: s_axi_rdata <= {24'h000000, ctrl_sys};
                    SEL_STATUS: s_axi_rdata <= {31'h00000000, control_sync_busy};
                    SEL_IRQ_EN: s_axi_rdata <= {31'h00000000, irq_enable};
                    SEL_IRQ_FLAG: s_axi_rdata <= {31'h00000000, irq_flag};
                    SEL_DEBUG: s_axi_rdata <= {31'h00000000, run_when_halted};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `RTCPIT_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// >>> test/rtcpit_properties.sv
`timescale 1ns/1ns
`default_nettype none
module rtcpit_properties (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Timer outputs
    input wire logic tick_irq,
    input wire logic tick_event
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    chk_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    chk_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted during read data");
    chk_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted during response");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    chk_event_gap: assert property (tick_event |=> !tick_event [*8])
        else $error("tick events too close");
    chk_irq_fall: assert property ($fell(tick_irq) |-> $past(s_axi_bvalid))
        else $error("interrupt fell without a write");
    chk_reset_quiet: assert property (disable iff (1'b0) !aresetn
        |=> !s_axi_bvalid && !s_axi_rvalid && !tick_irq && !tick_event)
        else $error("outputs active in reset");
endmodule
`default_nettype wire

// >>> test/rtcpit_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module rtcpit_tb_top;
    logic aclk = 1'b0, aresetn = 1'b0, rtc_clk_in = 1'b0, cpu_debug_halted = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] rtc_div = 2'h0;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic tick_irq, tick_event;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    logic [7:0] regs [5] = '{8'h40, 8'h44, 8'h48, 8'h4C, 8'h54};
    logic [7:0] quiet [3] = '{8'h01, 8'h79, 8'h08};
    logic [31:0] d;
    logic [1:0] r;
    int miscompares = 0, check_count = 0, n, c;

    rtcpit_top i_rtcpit_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .rtc_clk_in, .cpu_debug_halted, .tick_irq, .tick_event);

    initial forever #5 aclk = ~aclk;
    // The RTC clock toggles on every fourth system clock edge.
    always @(posedge aclk) begin
        rtc_div <= rtc_div + 2'h1;
        if (rtc_div == 2'h3)
            rtc_clk_in <= ~rtc_clk_in;
    end

    task stop_test;
        begin
            $display("miscompares %0d check_count %0d", miscompares, check_count);
            if (miscompares == 0 && check_count > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            check_count++;
            if (got !== exp) begin
                miscompares++;
                $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    task hang(input int k, input int lim);
        if (k >= lim) begin
            miscompares++;
            stop_test;
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] v);
        begin
            s_axi_awaddr <= a;
            s_axi_wdata <= v;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            n = 0;
            do begin
                @(posedge aclk);
                if (s_axi_awready)
                    s_axi_awvalid <= 1'b0;
                if (s_axi_wready)
                    s_axi_wvalid <= 1'b0;
                n++;
            end while (n < 50 && s_axi_bvalid !== 1'b1);
            hang(n, 50);
            s_axi_bready <= 1'b1;
            @(posedge aclk);
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
        end
    endtask

    task rd(input logic [7:0] a);
        begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            n = 0;
            do begin
                @(posedge aclk);
                if (s_axi_arready)
                    s_axi_arvalid <= 1'b0;
                n++;
            end while (n < 50 && s_axi_rvalid !== 1'b1);
            hang(n, 50);
            s_axi_rready <= 1'b1;
            @(posedge aclk);
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
        end
    endtask

    // Counts clock edges up to the next tick event.
    task ev(input int lim, input bit must);
        begin
            n = 0;
            do begin
                @(posedge aclk);
                n++;
            end while (n < lim && tick_event !== 1'b1);
            if (must)
                hang(n, lim);
        end
    endtask

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        foreach (regs[i]) begin
            rd(regs[i]);
            chk(d, 32'h0);
        end
        rd(8'h50);
        chk(r, 2'h2);
        wr(8'h50, 32'h1);
        chk(r, 2'h2);
        wr(8'h40, 32'h9);
        rd(8'h44);
        chk(d, 32'h1);
        repeat (40) @(posedge aclk);
        rd(8'h44);
        chk(d, 32'h0);
        rd(8'h40);
        chk(d, 32'h9);
        // One RTC cycle is eight system clocks.
        for (c = 1; c < 4; c++) begin
            wr(8'h40, (c << 3) | 1);
            repeat (40) @(posedge aclk);
            ev(2000, 1);
            ev(2000, 1);
            chk(n, 32 << (c - 1));
        end
        foreach (quiet[i]) begin
            wr(8'h40, quiet[i]);
            repeat (40) @(posedge aclk);
            ev(600, 0);
            chk(n, 600);
        end
        rd(8'h4C);
        chk(d, 32'h1);
        chk(tick_irq, 1'b0);
        wr(8'h48, 32'h1);
        @(posedge aclk);
        chk(tick_irq, 1'b1);
        // A write without byte lane 0 is answered but changes nothing.
        s_axi_wstrb <= 4'hE;
        wr(8'h48, 32'h0);
        chk(r, 2'h0);
        s_axi_wstrb <= 4'hF;
        rd(8'h48);
        chk(d, 32'h1);
        wr(8'h4C, 32'h0);
        rd(8'h4C);
        chk(d, 32'h1);
        wr(8'h4C, 32'h1);
        @(posedge aclk);
        chk(tick_irq, 1'b0);
        rd(8'h4C);
        chk(d, 32'h0);
        wr(8'h40, 32'h9);
        cpu_debug_halted <= 1'b1;
        repeat (40) @(posedge aclk);
        ev(600, 0);
        chk(n, 600);
        wr(8'h54, 32'h1);
        repeat (40) @(posedge aclk);
        ev(2000, 1);
        ev(2000, 1);
        chk(n, 32);
        // A reset in mid-run clears the flag, the request and the timer.
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk(tick_irq, 1'b0);
        rd(8'h4C);
        chk(d, 32'h0);
        rd(8'h40);
        chk(d, 32'h0);
        ev(600, 0);
        chk(n, 600);
        stop_test;
    end
endmodule

bind rtcpit_top rtcpit_properties i_rtcpit_properties (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .tick_irq(tick_irq),
    .tick_event(tick_event)
);
`default_nettype wire
